/* File: logic/msh_cfg.svh */
/*
 * Constants of the five-signal mote serial port: link rate, handshake timing and buffer sizes.
 * Assumes a 200 MHz core clock and an idle-high line on every serial and handshake signal.
 */
`ifndef MSH_CFG_SVH
`define MSH_CFG_SVH

// ************************************************************
// clock and link rate
// ************************************************************
`define MSH_CLK_HZ           200000000
`define MSH_BAUD             115200
`define MSH_BIT_CYC          16'((`MSH_CLK_HZ) / (`MSH_BAUD))
`define MSH_HALF_CYC         16'((`MSH_CLK_HZ) / (2 * `MSH_BAUD))
// the mote's receiver wants 1.5 stop bits at this rate
`define MSH_HOST_STOP_CYC    16'((3 * `MSH_CLK_HZ) / (2 * `MSH_BAUD))
`define MSH_DATA_BITS        8
`define MSH_STOP_IDX         4'h9

// ************************************************************
// handshake timing
// ************************************************************
`define MSH_REQ_TIMEOUT_MS   500
`define MSH_REQ_TIMEOUT_CYC  (32'(`MSH_REQ_TIMEOUT_MS) * 32'(`MSH_CLK_HZ / 1000))
`define MSH_RETRY_DELAY_MS   500
`define MSH_RETRY_DELAY_CYC  (32'(`MSH_RETRY_DELAY_MS) * 32'(`MSH_CLK_HZ / 1000))
`define MSH_ACK_PULSE_NS     500
`define MSH_ACK_PULSE_CYC    8'((`MSH_ACK_PULSE_NS * (`MSH_CLK_HZ / 1000000) + 999) / 1000)

// ************************************************************
// buffering
// ************************************************************
`define MSH_FIFO_DEPTH       16
`define MSH_FIFO_WIDTH       9

`endif

/* File: logic/msh_host.sv */
/*
 * Host end of the serial port: receiver with per-byte clear-to-send ack pulse, transmitter
 * gated by the mote's accepts-packets line, wake output and timestamp trigger pulse.
 * Assumes the mote end on msh_if; link inputs are synchronous to core_clk_in.
 */
`timescale 1ns/1ps

module msh_host (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   // link
   msh_if.host             bus,
   // inbound bytes from the mote
   output      logic [7:0] rx_data_out,
   output      logic       rx_valid_out,
   input  wire logic       rx_ready_in,
   output      logic       wake_out,
   // outbound bytes to the mote
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_first_in,
   input  wire logic       tx_local_in,
   input  wire logic       tx_valid_in,
   output      logic       tx_ready_out,
   // timestamp
   input  wire logic       ts_req_in
);
   import msh_pkg::*;

   typedef struct packed {
      msh_rx_s    rx;
      msh_tx_s    tx;
      logic [7:0] ack_cnt;
      logic [7:0] ts_cnt;
      logic       cts_n;
   } msh_host_s;

   msh_host_s r;
   msh_host_s nxt;

   // a network packet may only open while the mote accepts it; local commands always pass
   assign tx_ready_out = ~r.tx.busy
                       & ~(tx_first_in & ~tx_local_in & bus.mote_accepts_packets_n);

   always_comb begin
      nxt    = r;
      nxt.rx = msh_rx_step(r.rx, bus.mote_tx);
      nxt.tx = msh_tx_step(r.tx, `MSH_HOST_STOP_CYC);
      if (tx_valid_in && tx_ready_out) begin
         nxt.tx = msh_tx_load(tx_data_in);
      end
      // ack starts mid stop bit, far inside the inter-byte limit
      if (r.rx.vld) begin
         nxt.ack_cnt = `MSH_ACK_PULSE_CYC;
      end else if (r.ack_cnt != '0) begin
         nxt.ack_cnt = r.ack_cnt - 8'h1;
      end
      // held low whenever ready and no ack pulse is running, so a request is answered at once
      nxt.cts_n = (nxt.ack_cnt != '0) | ~rx_ready_in;
      if (ts_req_in) begin
         nxt.ts_cnt = `MSH_ACK_PULSE_CYC;
      end else if (r.ts_cnt != '0) begin
         nxt.ts_cnt = r.ts_cnt - 8'h1;
      end
      if (reset_in) begin
         nxt.rx      = '0;
         nxt.tx      = '0;
         nxt.tx.txd  = 1'b1;
         nxt.ack_cnt = '0;
         nxt.ts_cnt  = '0;
         nxt.cts_n   = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      r <= nxt;
   end

   assign bus.host_tx              = r.tx.txd;
   assign bus.host_clear_to_send_n = r.cts_n;
   assign bus.timestamp_trigger_n  = (r.ts_cnt == '0);
   assign rx_data_out              = r.rx.data;
   assign rx_valid_out             = r.rx.vld;
   assign wake_out                 = ~bus.mote_request_to_send_n;
endmodule

/* File: logic/msh_if.sv */
/*
 * The five serial wires plus timestamp trigger between mote and host.
 * Assumes both ends run on the same core clock; every line idles high.
 */
`timescale 1ns/1ps

interface msh_if;
   logic mote_tx;
   logic host_tx;
   logic mote_request_to_send_n;
   logic host_clear_to_send_n;
   logic mote_accepts_packets_n;
   logic timestamp_trigger_n;

   modport mote (
      output mote_tx,
      output mote_request_to_send_n,
      output mote_accepts_packets_n,
      input  host_tx,
      input  host_clear_to_send_n,
      input  timestamp_trigger_n
   );

   modport host (
      input  mote_tx,
      input  mote_request_to_send_n,
      input  mote_accepts_packets_n,
      output host_tx,
      output host_clear_to_send_n,
      output timestamp_trigger_n
   );
endinterface

/* File: logic/msh_mote.sv */
/*
 * Mote end of the serial port: outbound packet buffer, request and retry, per-byte paced
 * transmitter, receiver, accepts-packets gate and timestamp trigger.
 * Assumes the host end on msh_if and the mote core on the user ports.
 */
`timescale 1ns/1ps

// ************************************************************
// buffer
// ************************************************************
module msh_fifo #(
   parameter int W = `MSH_FIFO_WIDTH,
   parameter int D = `MSH_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         reset_in,
   // fill side
   input  wire logic         wr_valid_in,
   output      logic         wr_ready_out,
   input  wire logic [W-1:0] wr_data_in,
   // drain side
   output      logic         rd_valid_out,
   input  wire logic         rd_ready_in,
   output      logic [W-1:0] rd_data_out
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [CW-1:0]       cnt;
   } msh_fifo_s;

   msh_fifo_s r;
   msh_fifo_s nxt;
   logic      push;
   logic      pop;

   assign wr_ready_out = (r.cnt != CW'(D));
   assign rd_valid_out = (r.cnt != '0);
   assign rd_data_out  = r.mem[r.rd];
   assign push         = wr_valid_in & wr_ready_out;
   assign pop          = rd_valid_out & rd_ready_in;

   always_comb begin
      nxt = r;
      if (push) begin
         nxt.mem[r.wr] = wr_data_in;
         nxt.wr        = (r.wr == AW'(D - 1)) ? '0 : r.wr + AW'(1);
      end
      if (pop) begin
         nxt.rd = (r.rd == AW'(D - 1)) ? '0 : r.rd + AW'(1);
      end
      nxt.cnt = r.cnt + CW'(push) - CW'(pop);
      if (reset_in) begin
         nxt.wr  = '0;
         nxt.rd  = '0;
         nxt.cnt = '0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      r <= nxt;
   end
endmodule

// ************************************************************
// mote end
// ************************************************************
module msh_mote #(
   parameter logic [31:0] REQ_TIMEOUT_CYC = `MSH_REQ_TIMEOUT_CYC,
   parameter logic [31:0] RETRY_DELAY_CYC = `MSH_RETRY_DELAY_CYC
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   // link
   msh_if.mote             bus,
   // outbound bytes, last marks end of packet
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_last_in,
   input  wire logic       tx_valid_in,
   output      logic       tx_ready_out,
   // inbound bytes
   output      logic [7:0] rx_data_out,
   output      logic       rx_valid_out,
   // network and buffer state
   input  wire logic       network_joined_in,
   input  wire logic       buffer_room_in,
   // timestamp
   output      logic       timestamp_req_out
);
   import msh_pkg::*;

   typedef struct packed {
      msh_mote_st_e st;
      logic [31:0]  tmr;
      msh_tx_s      tx;
      logic         last;
      msh_ack_e     ack;
      logic [1:0]   cts_sy;
      logic         cts_d;
      logic [1:0]   rx_sy;
      msh_rx_s      rx;
      logic [1:0]   ts_sy;
      logic         ts_d;
      logic         ts_pls;
      logic         rts_n;
      logic         acc_n;
   } msh_mote_s;

   msh_mote_s       r;
   msh_mote_s       nxt;
   logic            f_vld;
   logic            f_pop;
   logic [8:0]      f_data;
   logic            rise;
   logic            fall;
   logic            start;

   msh_fifo #(.W(`MSH_FIFO_WIDTH), .D(`MSH_FIFO_DEPTH)) u_fifo (
      .core_clk_in  (core_clk_in),
      .reset_in     (reset_in),
      .wr_valid_in  (tx_valid_in),
      .wr_ready_out (tx_ready_out),
      .wr_data_in   ({tx_last_in, tx_data_in}),
      .rd_valid_out (f_vld),
      .rd_ready_in  (f_pop),
      .rd_data_out  (f_data)
   );

   // edges only from the second sync stage
   assign rise = r.cts_sy[1] & ~r.cts_d;
   assign fall = ~r.cts_sy[1] & r.cts_d;

   always_comb begin
      nxt        = r;
      start      = 1'b0;
      f_pop      = 1'b0;
      nxt.cts_sy = {r.cts_sy[0], bus.host_clear_to_send_n};
      nxt.cts_d  = r.cts_sy[1];
      nxt.rx_sy  = {r.rx_sy[0], bus.host_tx};
      nxt.ts_sy  = {r.ts_sy[0], bus.timestamp_trigger_n};
      nxt.ts_d   = r.ts_sy[1];
      nxt.ts_pls = ~r.ts_sy[1] & r.ts_d;
      // local command and network traffic alike are received here
      nxt.rx     = msh_rx_step(r.rx, r.rx_sy[1]);
      nxt.acc_n  = ~(network_joined_in & buffer_room_in);
      nxt.tx     = msh_tx_step(r.tx, `MSH_BIT_CYC);
      // the ack pulse may fall inside the stop bit, so it is tracked while sending too
      if (rise) begin
         nxt.ack = A_ROSE;
      end else if (fall && r.ack == A_ROSE) begin
         nxt.ack = A_FELL;
      end
      unique case (r.st)
         M_IDLE: begin
            if (f_vld) begin
               nxt.st    = M_REQ;
               nxt.rts_n = 1'b0;
               nxt.tmr   = '0;
            end
         end
         M_REQ: begin
            if (!r.cts_sy[1]) begin
               start = 1'b1;
            end else if (r.tmr == REQ_TIMEOUT_CYC - 32'h1) begin
               nxt.st    = M_RETRY;
               nxt.rts_n = 1'b1;
               nxt.tmr   = '0;
            end else begin
               nxt.tmr = r.tmr + 32'h1;
            end
         end
         M_RETRY: begin
            if (r.tmr == RETRY_DELAY_CYC - 32'h1) begin
               nxt.st    = M_REQ;
               nxt.rts_n = 1'b0;
               nxt.tmr   = '0;
            end else begin
               nxt.tmr = r.tmr + 32'h1;
            end
         end
         M_SEND: begin
            if (!nxt.tx.busy) begin
               nxt.st = r.last ? M_IDLE : M_WAIT;
               if (r.last) begin
                  nxt.rts_n = 1'b1;
               end
            end
         end
         M_WAIT: begin
            // an empty buffer mid-packet simply stretches the gap
            if (r.ack == A_FELL && f_vld) begin
               start = 1'b1;
            end
         end
      endcase
      if (start) begin
         f_pop    = 1'b1;
         nxt.tx   = msh_tx_load(f_data[7:0]);
         nxt.last = f_data[8];
         nxt.ack  = A_NONE;
         nxt.st   = M_SEND;
      end
      if (reset_in) begin
         nxt.st     = M_IDLE;
         nxt.tmr    = '0;
         nxt.tx     = '0;
         nxt.tx.txd = 1'b1;
         nxt.last   = 1'b0;
         nxt.ack    = A_NONE;
         nxt.cts_sy = 2'h3;
         nxt.cts_d  = 1'b1;
         nxt.rx_sy  = 2'h3;
         nxt.rx     = '0;
         nxt.ts_sy  = 2'h3;
         nxt.ts_d   = 1'b1;
         nxt.ts_pls = 1'b0;
         nxt.rts_n  = 1'b1;
         nxt.acc_n  = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      r <= nxt;
   end

   assign bus.mote_tx                = r.tx.txd;
   assign bus.mote_request_to_send_n = r.rts_n;
   assign bus.mote_accepts_packets_n = r.acc_n;
   assign rx_data_out                = r.rx.data;
   assign rx_valid_out               = r.rx.vld;
   assign timestamp_req_out          = r.ts_pls;
endmodule

/* File: logic/msh_pkg.sv */
/*
 * Types and character helpers shared by both ends of the mote serial port.
 * Assumes msh_cfg.svh on the include path.
 */
`include "msh_cfg.svh"

package msh_pkg;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} msh_rx_st_e;
   typedef enum logic [2:0] {M_IDLE, M_REQ, M_RETRY, M_SEND, M_WAIT} msh_mote_st_e;
   typedef enum logic [1:0] {A_NONE, A_ROSE, A_FELL} msh_ack_e;

   typedef struct packed {
      msh_rx_st_e  st;
      logic [15:0] cnt;
      logic [2:0]  bitn;
      logic [7:0]  data;
      logic        vld;
   } msh_rx_s;

   typedef struct packed {
      logic        busy;
      logic [15:0] cnt;
      logic [3:0]  bitn;
      logic [8:0]  shf;
      logic        txd;
   } msh_tx_s;

   // ************************************************************
   // character receiver: samples mid-bit, drops false starts
   // ************************************************************
   function automatic msh_rx_s msh_rx_step(msh_rx_s s, logic rxd);
      msh_rx_s n;
      n     = s;
      n.vld = 1'b0;
      n.cnt = s.cnt + 16'h1;
      unique case (s.st)
         RX_IDLE: begin
            n.cnt = '0;
            if (!rxd) begin
               n.st = RX_START;
            end
         end
         RX_START: begin
            if (s.cnt == `MSH_HALF_CYC - 16'h1) begin
               n.cnt  = '0;
               n.bitn = '0;
               n.st   = rxd ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (s.cnt == `MSH_BIT_CYC - 16'h1) begin
               n.cnt  = '0;
               n.data = {rxd, s.data[7:1]};
               n.bitn = s.bitn + 3'h1;
               if (s.bitn == 3'(`MSH_DATA_BITS - 1)) begin
                  n.st = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (s.cnt == `MSH_BIT_CYC - 16'h1) begin
               n.st  = RX_IDLE;
               n.vld = rxd; // framing error drops the byte
            end
         end
      endcase
      return n;
   endfunction

   // ************************************************************
   // character transmitter
   // ************************************************************
   function automatic msh_tx_s msh_tx_load(logic [7:0] d);
      msh_tx_s n;
      n.busy = 1'b1;
      n.cnt  = '0;
      n.bitn = '0;
      n.shf  = {1'b1, d};
      n.txd  = 1'b0;
      return n;
   endfunction

   function automatic msh_tx_s msh_tx_step(msh_tx_s s, logic [15:0] stop_cyc);
      msh_tx_s n;
      n = s;
      if (s.busy) begin
         n.cnt = s.cnt + 16'h1;
         if (s.bitn == `MSH_STOP_IDX) begin
            if (s.cnt == stop_cyc - 16'h1) begin
               n.busy = 1'b0;
               n.cnt  = '0;
            end
         end else if (s.cnt == `MSH_BIT_CYC - 16'h1) begin
            n.cnt  = '0;
            n.txd  = s.shf[0];
            n.shf  = {1'b1, s.shf[8:1]};
            n.bitn = s.bitn + 4'h1;
         end
      end
      return n;
   endfunction

endpackage

/* File: tb/msh_link_asserts.sv */
/*
 * Concurrent checks on the wires that join the mote end and the host end.
 * Assumes one core clock, synchronous active-high reset and msh_cfg.svh on the include path.
 */
`timescale 1ns/1ps
`include "msh_cfg.svh"

module msh_link_asserts #(
   parameter logic [31:0] REQ_TIMEOUT_CYC = `MSH_REQ_TIMEOUT_CYC,
   parameter logic [31:0] RETRY_DELAY_CYC = `MSH_RETRY_DELAY_CYC
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // link wires
   input wire logic mote_tx,
   input wire logic host_tx,
   input wire logic mote_request_to_send_n,
   input wire logic host_clear_to_send_n,
   input wire logic mote_accepts_packets_n,
   input wire logic timestamp_trigger_n
);
   localparam int          BIT       = int'(`MSH_BIT_CYC);
   localparam int          HALF      = int'(`MSH_HALF_CYC);
   localparam logic [31:0] MID_START = 32'(9 * BIT + 1);
   logic [31:0] req_cnt_r;
   logic [31:0] hi_cnt_r;
   logic [31:0] frm_r;
   logic [31:0] cts_hi_r;
   logic        retry_r;
   logic        sent_r;
   logic        acked_r;
   logic        tx_q_r;
   logic        rts_q_r;
   logic        start_w;

   // ************************************************************
   // helper logic
   // ************************************************************
   // data bits also fall, so a start only counts outside a running frame
   assign start_w = tx_q_r & ~mote_tx & (frm_r == 32'h0);

   always_ff @(posedge core_clk_in) begin
      tx_q_r  <= mote_tx;
      rts_q_r <= mote_request_to_send_n;
      if (reset_in) begin
         req_cnt_r <= 32'h0;
         hi_cnt_r  <= 32'h0;
         frm_r     <= 32'h0;
         cts_hi_r  <= 32'h0;
         retry_r   <= 1'b0;
         sent_r    <= 1'b0;
         acked_r   <= 1'b0;
      end else begin
         req_cnt_r <= (mote_request_to_send_n | ~host_clear_to_send_n) ? 32'h0 : req_cnt_r + 32'h1;
         hi_cnt_r  <= mote_request_to_send_n ? hi_cnt_r + 32'h1 : 32'h0;
         cts_hi_r  <= host_clear_to_send_n ? cts_hi_r + 32'h1 : 32'h0;
         frm_r     <= start_w ? 32'(9 * BIT + HALF) : (frm_r != 32'h0 ? frm_r - 32'h1 : 32'h0);
         retry_r   <= (mote_request_to_send_n & ~rts_q_r & host_clear_to_send_n) |
                      (retry_r & mote_request_to_send_n);
         sent_r    <= ~mote_request_to_send_n & (sent_r | start_w);
         acked_r   <= ~start_w & (acked_r | (host_clear_to_send_n & cts_hi_r == 32'h0));
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   reset_idle_a: assert property ($fell(reset_in) |-> mote_request_to_send_n &&
      mote_accepts_packets_n && mote_tx && host_tx && host_clear_to_send_n)
      else $error("link lines not idle after reset");
   request_hold_a: assert property (req_cnt_r <= REQ_TIMEOUT_CYC)
      else $error("request held past its timeout");
   request_timeout_a: assert property ($rose(mote_request_to_send_n) && host_clear_to_send_n
      |-> req_cnt_r == REQ_TIMEOUT_CYC)
      else $error("request released before its timeout");
   retry_bound_a: assert property (retry_r |-> hi_cnt_r <= RETRY_DELAY_CYC)
      else $error("retry later than its delay");
   retry_exact_a: assert property ($fell(mote_request_to_send_n) && retry_r
      |-> hi_cnt_r == RETRY_DELAY_CYC)
      else $error("retry delay length wrong");
   send_request_a: assert property (start_w |-> !mote_request_to_send_n)
      else $error("byte sent without a request");
   byte_pacing_a: assert property (start_w && sent_r |-> acked_r && !host_clear_to_send_n)
      else $error("next byte started without an ack pulse");
   ack_width_a: assert property ($fell(host_clear_to_send_n)
      |-> cts_hi_r >= 32'(`MSH_ACK_PULSE_CYC))
      else $error("ack pulse too short");
   start_bit_a: assert property (frm_r == MID_START |-> !mote_tx)
      else $error("start bit not low");
   stop_bit_a: assert property (frm_r == 32'h1 |-> mote_tx)
      else $error("stop bit not high");
   trigger_width_a: assert property ($fell(timestamp_trigger_n)
      |-> ##99 !timestamp_trigger_n ##1 timestamp_trigger_n)
      else $error("timestamp trigger pulse length wrong");

   cover property ($rose(mote_request_to_send_n) && host_clear_to_send_n);
   cover property (start_w && sent_r);
   cover property ($fell(timestamp_trigger_n));
endmodule

/* File: tb/tb_top.sv */
/*
 * Bench joining both ends of the mote serial port; the outbound buffer is reached through the mote.
 * Assumes the design files and msh_cfg.svh are compiled first.
 */
`timescale 1ns/1ps
`include "msh_cfg.svh"

module tb_top;
   import msh_pkg::*;
   localparam logic [31:0] REQ_TO = 32'h000000C8;
   localparam logic [31:0] RETRY  = 32'h00000032;
   localparam int          BIT    = int'(`MSH_BIT_CYC);
   logic       core_clk_in;
   logic       reset_in;
   logic [7:0] m_td, m_rd, h_td, h_rd;
   logic       m_tl, m_tv, m_tr, m_rv, m_join, m_room, m_ts;
   logic       h_rv, h_rr, h_wake, h_tf, h_tl, h_tv, h_tr, h_ts;
   logic [7:0] q_h[$], q_m[$], q_wm[$], q_wh[$];
   logic [31:0] seed;
   int         checks, miscompares, ts_cnt, n;

   // ************************************************************
   // design under test
   // ************************************************************
   msh_if u_msh_if ();
   msh_mote #(.REQ_TIMEOUT_CYC(REQ_TO), .RETRY_DELAY_CYC(RETRY)) u_msh_mote (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .bus(u_msh_if.mote),
      .tx_data_in(m_td), .tx_last_in(m_tl), .tx_valid_in(m_tv), .tx_ready_out(m_tr),
      .rx_data_out(m_rd), .rx_valid_out(m_rv), .network_joined_in(m_join),
      .buffer_room_in(m_room), .timestamp_req_out(m_ts));
   msh_host u_msh_host (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .bus(u_msh_if.host),
      .rx_data_out(h_rd), .rx_valid_out(h_rv), .rx_ready_in(h_rr), .wake_out(h_wake),
      .tx_data_in(h_td), .tx_first_in(h_tf), .tx_local_in(h_tl), .tx_valid_in(h_tv),
      .tx_ready_out(h_tr), .ts_req_in(h_ts));
   msh_link_asserts #(.REQ_TIMEOUT_CYC(REQ_TO), .RETRY_DELAY_CYC(RETRY)) u_msh_link_asserts (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .mote_tx(u_msh_if.mote_tx),
      .host_tx(u_msh_if.host_tx), .mote_request_to_send_n(u_msh_if.mote_request_to_send_n),
      .host_clear_to_send_n(u_msh_if.host_clear_to_send_n),
      .mote_accepts_packets_n(u_msh_if.mote_accepts_packets_n),
      .timestamp_trigger_n(u_msh_if.timestamp_trigger_n));

   // ************************************************************
   // helpers
   // ************************************************************
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task step(input int k);
      repeat (k) @(posedge core_clk_in);
      #1;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // valid is left high so back-to-back bytes never lower it inside one time step
   task mote_put(input logic [7:0] d, input logic l);
      m_td = d;
      m_tl = l;
      m_tv = 1'b1;
      @(posedge core_clk_in);
      while (m_tr !== 1'b1) @(posedge core_clk_in);
      #1;
      q_h.push_back(d);
      q_wm.push_back(d);
   endtask

   task host_put(input logic [7:0] d, input logic f, input logic lc);
      h_td = d;
      h_tf = f;
      h_tl = lc;
      h_tv = 1'b1;
      @(posedge core_clk_in);
      while (h_tr !== 1'b1) @(posedge core_clk_in);
      #1;
      q_m.push_back(d);
      q_wh.push_back(d);
   endtask

   task run(input logic lv);
      n = 0;
      while (u_msh_if.mote_request_to_send_n === lv && n < 5000) begin
         step(1);
         n++;
      end
   endtask

   // bench's own reading of each serial line, sampled mid-bit
   task automatic wire_rx(input bit sel);
      logic [7:0] b;
      forever begin
         if (sel) @(negedge u_msh_if.host_tx);
         else @(negedge u_msh_if.mote_tx);
         repeat (BIT / 2) @(posedge core_clk_in);
         chk(sel ? u_msh_if.host_tx : u_msh_if.mote_tx, 32'h0);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge core_clk_in);
            b = {sel ? u_msh_if.host_tx : u_msh_if.mote_tx, b[7:1]};
         end
         repeat (BIT) @(posedge core_clk_in);
         chk(sel ? u_msh_if.host_tx : u_msh_if.mote_tx, 32'h1);
         chk(b, sel ? q_wh.pop_front() : q_wm.pop_front());
      end
   endtask

   initial wire_rx(1'b0);
   initial wire_rx(1'b1);

   always @(posedge core_clk_in) begin
      if (h_rv === 1'b1) chk(h_rd, q_h.pop_front());
      if (m_rv === 1'b1) chk(m_rd, q_m.pop_front());
      if (h_rv === 1'b1) chk(u_msh_if.mote_request_to_send_n, 32'h0);
      if (m_ts === 1'b1) ts_cnt++;
   end

   initial begin
      repeat (150000) @(posedge core_clk_in);
      miscompares++;
      end_sim();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {m_td, m_tl, m_tv, m_join, m_room, h_rr, h_td, h_tf, h_tl, h_tv, h_ts} = '0;
      checks = 0;
      miscompares = 0;
      ts_cnt = 0;
      seed = 32'h61EDC236;
      reset_in = 1'b1;
      step(20);
      reset_in = 1'b0;
      step(1);
      chk(u_msh_if.mote_accepts_packets_n, 32'h1);
      // an empty outbound buffer takes bytes and raises no request
      chk(m_tr, 32'h1);
      step(3);
      chk(u_msh_if.mote_request_to_send_n, 32'h1);
      seed = lfsr(seed);
      h_td = seed[7:0];
      h_tf = 1'b1;
      h_tv = 1'b1;
      step(3);
      chk(h_tr, 32'h0);
      h_tv = 1'b0;
      fork
         begin
            seed = lfsr(seed);
            host_put(seed[7:0], 1'b1, 1'b1);
            m_join = 1'b1;
            step(4);
            chk(u_msh_if.mote_accepts_packets_n, 32'h1);
            m_room = 1'b1;
            step(4);
            chk(u_msh_if.mote_accepts_packets_n, 32'h0);
            seed = lfsr(seed);
            host_put(seed[7:0], 1'b1, 1'b0);
            seed = lfsr(seed);
            host_put(seed[7:0], 1'b0, 1'b0);
            h_tv = 1'b0;
         end
         begin
            seed = lfsr(seed);
            mote_put(seed[7:0], 1'b0);
            seed = lfsr(seed);
            mote_put(seed[7:0], 1'b1);
            m_tv = 1'b0;
            run(1'b1);
            chk(h_wake, 32'h1);
            run(1'b0);
            chk(n, REQ_TO);
            run(1'b1);
            chk(n, RETRY);
            h_rr = 1'b1;
         end
      join
      h_ts = 1'b1;
      step(1);
      h_ts = 1'b0;
      step(110);
      chk(ts_cnt, 32'h1);
      for (int i = 0; i < 90000 && q_h.size() + q_m.size() + q_wm.size() + q_wh.size() > 0; i++)
         step(1);
      chk(q_h.size() + q_m.size() + q_wm.size() + q_wh.size(), 32'h0);
      end_sim();
   end
endmodule
